/* File: core/fec_pkg.sv */
package fec_pkg;
    // ==========================================================
    // opcodes
    localparam logic [7:0] FEC_OP_PAGE = 8'h81;
    localparam logic [7:0] FEC_OP_BLOCK = 8'h50;
    localparam logic [7:0] FEC_OP_SECTOR = 8'h7c;
    // ==========================================================
    // frame layout
    localparam int FEC_CMD_BITS = 32;
    localparam int FEC_PAGE_W = 15;
    localparam int FEC_STD_PAGE_LSB = 9;
    localparam int FEC_BIN_PAGE_LSB = 8;
    localparam int FEC_BLOCK_SHIFT = 3;
    localparam int FEC_SECT_SHIFT = 10;
    localparam int FEC_LADDR_W = 23;
    localparam int FEC_PAGES_PER_BLOCK = 8;
    localparam int FEC_PAGES_PER_SECT0 = 8;
    // ==========================================================
    // timing: maximum erase times in ns, cycles at 4 ns
    localparam int FEC_CLK_NS = 4;
    localparam int FEC_PAGE_ERASE_MAX_NS = 35000;
    localparam int FEC_BLOCK_ERASE_MAX_NS = 50000;
    localparam int FEC_SECTOR_ERASE_MAX_NS = 200000;
    localparam int FEC_PAGE_CYC = FEC_PAGE_ERASE_MAX_NS / FEC_CLK_NS;
    localparam int FEC_BLOCK_CYC = FEC_BLOCK_ERASE_MAX_NS / FEC_CLK_NS;
    localparam int FEC_SECTOR_CYC = FEC_SECTOR_ERASE_MAX_NS / FEC_CLK_NS;
    localparam int FEC_CNT_W = 24;
    // ==========================================================
    // erase kinds
    typedef enum logic [1:0] {
        FEC_K_PAGE = 2'b00,
        FEC_K_BLOCK = 2'b01,
        FEC_K_SECTOR = 2'b10,
        FEC_K_NONE = 2'b11
    } fec_kind_t;
endpackage

/* File: core/fec_if.sv */
`timescale 1ns/1ns
`default_nettype none
// serial link: host drives chip select (low active), clock enable and data in
interface fec_if;
    logic cs_n;
    logic sclk_en;
    logic mosi;
    modport dev (input cs_n, input sclk_en, input mosi);
    modport host (output cs_n, output sclk_en, output mosi);
endinterface
`default_nettype wire

/* File: core/fec_device.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// - standard page erase: 81h, 15 page bits, 9 dummy
// - binary page erase: dummy, page bits, 8 dummy
// - cs rise after page erase erases page
// - busy flag while any erase runs
// - failed byte sets erase error flag
// - standard block erase: 50h, 12 bits, 12 dummy
// - binary block erase: dummy, 12 bits, 11 dummy
// - cs rise after block erase erases eight pages
// - block number 0..4095, low page bits ignored
// - sector erase 7Ch, one of 33 sectors
// - standard sector 0a/0b: 12 bits, bit 3 picks
// - standard sector 1-31: 5 bits, 19 dummy
// - binary sector 0a/0b: dummy, 12 bits, 11 dummy
// - binary sector 1-31: dummy, 5 bits, 18 dummy
// - any address in sector accepted
// - cs rise after sector erase erases sector
// - binary mode forms 23-bit logical address
module fec_device
    import fec_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial link
    fec_if.dev link,
    // configuration
    input wire logic binary_page_mode,
    // array verify result, sampled per erased page
    input wire logic verify_fail,
    // status
    output logic ready_busy_n,
    output logic erase_program_error_flag,
    // erase action toward the array model
    output logic erase_pulse,
    output logic [14:0] erase_first_page,
    output logic [15:0] erase_page_count,
    output logic [5:0] erase_sector_id
);
    import fec_pkg::*;

    typedef enum logic [1:0] {
        FEC_S_IDLE = 2'b00,
        FEC_S_SHIFT = 2'b01,
        FEC_S_ERASE = 2'b10
    } fec_dstate_t;

    fec_dstate_t state_r;
    logic cs_n_d_r;
    logic [31:0] shift_r;
    logic [5:0] nbits_r;
    logic mode_r;
    logic [FEC_CNT_W-1:0] timer_r;
    logic [15:0] pages_left_r;

    // ==========================================================
    // frame fields
    // the first 32 strobes fill shift_r: opcode on top, address bytes below
    wire cs_rise = link.cs_n & ~cs_n_d_r;
    wire [7:0] opcode = shift_r[31:24];
    wire [22:0] logical_byte_address = shift_r[22:0];

    // ==========================================================
    // page index per layout
    // standard: page index at bits 23:9, nine dummy bits below
    // binary: one dummy bit on top, page index at bits 22:8, eight dummy below
    wire [14:0] page_index_bits = mode_r ? logical_byte_address[22:8] : shift_r[23:9];
    // a block is eight pages, so the low three page bits never matter for it
    wire [11:0] block_num = page_index_bits[14:3];
    // sectors 1..31 only look at the top five page bits
    wire [4:0] sect_hi = page_index_bits[14:10];
    wire sect_zero = (sect_hi == 5'h00);

    // ==========================================================
    // sector map
    // when the top five bits are zero, page bit 3 alone splits 0a from 0b
    // sector id: 0 = 0a, 1 = 0b, 2..32 = sectors 1..31
    wire [5:0] sect_id = sect_zero ? {5'h00, page_index_bits[3]} : {1'b0, sect_hi} + 6'h01;

    // ==========================================================
    // command kind
    // a short frame or an unknown opcode decodes to none and starts nothing
    wire full_cmd = (nbits_r == 6'(FEC_CMD_BITS));
    wire fec_kind_t kind = !full_cmd ? FEC_K_NONE :
        (opcode == FEC_OP_PAGE) ? FEC_K_PAGE :
        (opcode == FEC_OP_BLOCK) ? FEC_K_BLOCK :
        (opcode == FEC_OP_SECTOR) ? FEC_K_SECTOR : FEC_K_NONE;

    // ==========================================================
    // erase extent
    wire [14:0] first_page = (kind == FEC_K_BLOCK) ? {block_num, 3'h0} :
        (kind == FEC_K_SECTOR) ? (sect_zero ? {11'h000, page_index_bits[3], 3'h0} : {sect_hi, 10'h000}) :
        page_index_bits;
    // sector 0a/0b count as one block each; sectors 1..31 as 1024 pages
    wire [15:0] sect_pages = sect_zero ? 16'(FEC_PAGES_PER_SECT0) : 16'h0400;
    wire [15:0] page_cnt = (kind == FEC_K_BLOCK) ? 16'(FEC_PAGES_PER_BLOCK) :
        (kind == FEC_K_SECTOR) ? sect_pages : 16'h0001;
    // slot length: the maximum erase time spread evenly over the pages, for any sector (0a/0b too) over 1024 pages,
    // so the whole operation never outlasts its maximum time
    wire [FEC_CNT_W-1:0] per_page_cyc = (kind == FEC_K_BLOCK) ? FEC_CNT_W'(FEC_BLOCK_CYC / FEC_PAGES_PER_BLOCK) :
        (kind == FEC_K_SECTOR) ? FEC_CNT_W'(FEC_SECTOR_CYC / 1024) : FEC_CNT_W'(FEC_PAGE_CYC);

    // ==========================================================
    // handshake between the shifter and the slot timer
    wire start = (state_r == FEC_S_SHIFT) && cs_rise && (kind != FEC_K_NONE);
    wire timer_done = (timer_r == '0);
    wire page_done = (state_r == FEC_S_ERASE) && timer_done;
    wire last_page = (pages_left_r == 16'h0001);
    logic [FEC_CNT_W-1:0] per_page_r;

    // ==========================================================
    // state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= FEC_S_IDLE;
            cs_n_d_r <= 1'b1;
            shift_r <= '0;
            nbits_r <= '0;
            mode_r <= 1'b0;
        end else begin
            cs_n_d_r <= link.cs_n;
            case (state_r)
                FEC_S_IDLE: begin
                    if (!link.cs_n) begin
                        state_r <= FEC_S_SHIFT;
                        nbits_r <= '0;
                        mode_r <= binary_page_mode;
                    end
                end
                FEC_S_SHIFT: begin
                    if (link.cs_n) begin
                        state_r <= start ? FEC_S_ERASE : FEC_S_IDLE;
                    end else if (link.sclk_en && nbits_r != 6'(FEC_CMD_BITS)) begin
                        // extra bits after the address are ignored
                        shift_r <= {shift_r[30:0], link.mosi};
                        nbits_r <= nbits_r + 6'h01;
                    end
                end
                FEC_S_ERASE: begin
                    // commands while busy are not accepted
                    if (page_done && last_page) begin
                        state_r <= FEC_S_IDLE;
                    end
                end
                default: state_r <= FEC_S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // start strobe and command descriptor, held until the next start
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            erase_pulse <= 1'b0;
            erase_first_page <= '0;
            erase_page_count <= '0;
            erase_sector_id <= '0;
        end else begin
            erase_pulse <= start;
            if (start) begin
                erase_first_page <= first_page;
                erase_page_count <= page_cnt;
                erase_sector_id <= sect_id;
            end
        end
    end

    // ==========================================================
    // page slot timer: one slot per page, reloaded at every slot end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            timer_r <= '0;
            per_page_r <= '0;
            pages_left_r <= '0;
        end else if (start) begin
            timer_r <= per_page_cyc - FEC_CNT_W'(1);
            per_page_r <= per_page_cyc;
            pages_left_r <= page_cnt;
        end else if (page_done) begin
            timer_r <= per_page_r - FEC_CNT_W'(1);
            pages_left_r <= pages_left_r - 16'h0001;
        end else if (state_r == FEC_S_ERASE) begin
            timer_r <= timer_r - FEC_CNT_W'(1);
        end
    end

    // ==========================================================
    // status: busy across all slots, error sticky for one operation
    // a failing slot may also be the last one; the set still lands
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ready_busy_n <= 1'b1;
            erase_program_error_flag <= 1'b0;
        end else if (start) begin
            ready_busy_n <= 1'b0;
            erase_program_error_flag <= 1'b0;
        end else if (page_done) begin
            if (verify_fail) begin
                erase_program_error_flag <= 1'b1;
            end
            if (last_page) begin
                ready_busy_n <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: core/fec_host.sv */
`timescale 1ns/1ns
`default_nettype none
module fec_host
    import fec_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // request
    input wire logic req_valid,
    input wire fec_pkg::fec_kind_t req_kind,
    input wire logic req_binary,
    input wire logic [14:0] req_page,
    output logic req_ready,
    // serial link
    fec_if.host link
);
    import fec_pkg::*;

    logic [31:0] frame_r;
    logic [5:0] left_r;
    logic active_r;

    // ==========================================================
    // frame build: opcode then three address bytes
    wire [7:0] op = (req_kind == FEC_K_BLOCK) ? FEC_OP_BLOCK :
        (req_kind == FEC_K_SECTOR) ? FEC_OP_SECTOR : FEC_OP_PAGE;
    // binary: dummy bit, page at 22:8, 8 dummy; standard: page at 23:9, 9 dummy
    wire [23:0] addr = req_binary ? {1'b0, req_page, 8'h00} : {req_page, 9'h000};
    wire go = req_valid && req_ready && (req_kind != FEC_K_NONE);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_r <= '0;
            left_r <= '0;
            active_r <= 1'b0;
            req_ready <= 1'b1;
            link.cs_n <= 1'b1;
            link.sclk_en <= 1'b0;
            link.mosi <= 1'b0;
        end else if (go) begin
            frame_r <= {op, addr};
            left_r <= 6'(FEC_CMD_BITS);
            active_r <= 1'b1;
            req_ready <= 1'b0;
            link.cs_n <= 1'b0;
            link.sclk_en <= 1'b0;
        end else if (active_r && left_r != 6'h00) begin
            link.sclk_en <= 1'b1;
            link.mosi <= frame_r[31];
            frame_r <= {frame_r[30:0], 1'b0};
            left_r <= left_r - 6'h01;
        end else if (active_r) begin
            // raising chip select launches the erase
            link.sclk_en <= 1'b0;
            link.cs_n <= 1'b1;
            active_r <= 1'b0;
            req_ready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/fec_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module fec_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // link
    input wire logic cs_n,
    input wire logic sclk_en,
    // host and device status
    input wire logic req_ready,
    input wire logic ready_busy_n,
    input wire logic erase_pulse,
    input wire logic erase_program_error_flag
);
    logic [5:0] bits_r;
    logic [5:0] bits_nxt;
    // ==========================================================
    // strobes seen in the current frame
    assign bits_nxt = cs_n ? 6'h00 : bits_r + {5'h00, sclk_en};
    always_ff @(posedge ref_clk) begin
        bits_r <= rst_n ? bits_nxt : 6'h00;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // link framing
    a_idle_no_strobe: assert property (cs_n |-> !sclk_en) else $error("strobe outside frame");
    a_lead_gap: assert property ($fell(cs_n) |-> !sclk_en ##1 sclk_en) else $error("bad lead gap");
    a_frame_bits: assert property ($rose(cs_n) |-> bits_r == 6'h20) else $error("frame not 32 bits");
    a_host_held: assert property (!cs_n |-> !req_ready) else $error("host ready in frame");
    // ==========================================================
    // erase start and status
    a_start_on_cs: assert property ($rose(cs_n) && ready_busy_n |-> ##[1:2] erase_pulse)
        else $error("no erase after frame");
    a_pulse_busy: assert property (erase_pulse |-> !ready_busy_n) else $error("pulse without busy");
    a_pulse_single: assert property (erase_pulse |=> !erase_pulse) else $error("pulse too long");
    a_no_restart: assert property (erase_pulse |-> $past(ready_busy_n)) else $error("start while busy");
    a_busy_hold: assert property ($fell(ready_busy_n) |=> !ready_busy_n[*8]) else $error("busy too short");
    a_err_clear: assert property (erase_pulse |-> ##2 !erase_program_error_flag) else $error("flag kept");
    a_err_sticky: assert property (ready_busy_n && $past(ready_busy_n) |-> $stable(erase_program_error_flag))
        else $error("flag moved while idle");
    c_erase: cover property (erase_pulse);
    c_refused: cover property ($rose(cs_n) && !ready_busy_n);
    c_error: cover property ($rose(erase_program_error_flag));
endmodule
`default_nettype wire

/* File: sim/flash_erase_command_decode_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module flash_erase_command_decode_tb;
    import fec_pkg::*;
    typedef struct {logic [14:0] first; logic [15:0] cnt; logic [5:0] id; logic sect; int slot; logic vf;} fec_note_t;
    logic ref_clk, rst_n, req_valid, req_binary, req_ready, binary_page_mode, verify_fail;
    logic ready_busy_n, erase_program_error_flag, erase_pulse;
    fec_kind_t req_kind;
    logic [14:0] req_page, erase_first_page;
    logic [15:0] erase_page_count;
    logic [5:0] erase_sector_id;
    int n_errors = 0, samples_checked = 0, seed = 20, pend = 0;
    fec_note_t notes[$];
    logic [63:0] fq[$];
    fec_if link();
    fec_host fec_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_kind(req_kind),
        .req_binary(req_binary), .req_page(req_page), .req_ready(req_ready), .link(link));
    fec_device fec_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .binary_page_mode(binary_page_mode),
        .verify_fail(verify_fail), .ready_busy_n(ready_busy_n), .erase_program_error_flag(erase_program_error_flag),
        .erase_pulse(erase_pulse), .erase_first_page(erase_first_page), .erase_page_count(erase_page_count),
        .erase_sector_id(erase_sector_id));
    fec_properties fec_properties_i (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk_en(link.sclk_en),
        .req_ready(req_ready), .ready_busy_n(ready_busy_n), .erase_pulse(erase_pulse),
        .erase_program_error_flag(erase_program_error_flag));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // closing
    task automatic test_done();
        $display("compared %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // request driver: notes the expected frame and erase
    task automatic send(input fec_kind_t k, input logic b, input logic [14:0] p, input logic nt);
        fec_note_t n;
        logic [14:0] km;
        int c;
        c = 0;
        while (req_ready !== 1'b1 && c < 1000) begin @(posedge ref_clk); c++; end
        n.vf = verify_fail; n.sect = (k == FEC_K_SECTOR); n.first = p; n.cnt = 16'h0001; n.slot = 8750; n.id = 6'h00;
        km = (k == FEC_K_PAGE) ? 15'h7fff : 15'h7ff8;
        if (k == FEC_K_BLOCK) begin n.first = {p[14:3], 3'h0}; n.cnt = 16'h0008; n.slot = 1562; end
        if (n.sect && p[14:10] == 5'h00) begin n.first = {p[14:3], 3'h0}; n.cnt = 16'h0008; n.id = {5'h00, p[3]}; end
        if (n.sect && p[14:10] != 5'h00) begin km = 15'h7c00; n.first = {p[14:10], 10'h000}; n.cnt = 16'h0400;
            n.id = {1'b0, p[14:10]} + 6'h01; end
        if (n.sect) n.slot = 48;
        fq.push_back({k == FEC_K_PAGE ? FEC_OP_PAGE : k == FEC_K_BLOCK ? FEC_OP_BLOCK : FEC_OP_SECTOR,
            24'(p & km) << (b ? 8 : 9), 8'hff, 24'(km) << (b ? 8 : 9)});
        if (nt) begin notes.push_back(n); pend++; end
        @(posedge ref_clk); #1;
        req_valid = 1'b1; req_kind = k; req_binary = b; req_page = p;
        @(posedge ref_clk); #1;
        req_valid = 1'b0;
    endtask
    // ==========================================================
    // wire watcher: bit order and fields of every frame
    initial begin : wire_mon
        logic [31:0] sh;
        logic [63:0] fe;
        logic low;
        low = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (link.cs_n === 1'b0 && link.sclk_en === 1'b1) sh = {sh[30:0], link.mosi};
            if (link.cs_n === 1'b0) low = 1'b1;
            else if (low) begin low = 1'b0; fe = fq.pop_front(); `CHK("frame", fe[63:32], sh & fe[31:0]) end
        end
    end
    // erase watcher: outputs at start, busy span, error flag
    initial begin : erase_mon
        fec_note_t n;
        int c;
        forever begin
            @(posedge ref_clk);
            if (erase_pulse === 1'b1) begin
                n = notes.pop_front();
                `CHK("first", n.first, erase_first_page)
                `CHK("count", n.cnt, erase_page_count)
                if (n.sect) `CHK("sector", n.id, erase_sector_id)
                c = 0;
                while (ready_busy_n !== 1'b1 && c < 60000) begin @(posedge ref_clk); c++; end
                `CHK("busy", 1'b1, c >= n.slot * n.cnt - 2 && c <= n.slot * n.cnt + 2)
                `CHK("error", n.vf, erase_program_error_flag)
                pend--;
            end
        end
    end
    initial begin : watchdog
        #400000;
        n_errors++;
        test_done();
    end
    // ==========================================================
    // main sequence: page, block, sector 0b, 0a, upper sector
    initial begin : main
        fec_kind_t ks[5] = '{FEC_K_PAGE, FEC_K_BLOCK, FEC_K_SECTOR, FEC_K_SECTOR, FEC_K_SECTOR};
        logic [14:0] p;
        int c;
        rst_n = 1'b0; req_valid = 1'b0; req_kind = FEC_K_NONE; req_binary = 1'b0; req_page = 15'h0000;
        binary_page_mode = 1'b0; verify_fail = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            p = 15'($random(seed));
            if (i == 2) p = {12'h001, p[2:0]};
            if (i == 3) p = {12'h000, p[2:0]};
            if (i == 4) p = p | 15'h4000;
            verify_fail = 1'($random(seed));
            binary_page_mode = i[0];
            send(ks[i], i[0], p, 1'b1);
            if (i == 0) send(FEC_K_BLOCK, 1'b0, 15'($random(seed)), 1'b0);
            c = 0;
            while (pend != 0 && c < 100000) begin @(posedge ref_clk); c++; end
            @(posedge ref_clk); #1;
        end
        test_done();
    end
endmodule
`default_nettype wire
